// ===== verif/sdic_motion_model.sv
// behavioural motion generator answering the control-input block
`timescale 1ns/10ps
`default_nettype none

module sdic_motion_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // commands from the block
    input wire logic motion_start,
    input wire logic motion_stop,
    input wire logic stop_immediate,
    // run length and live selection
    input wire logic [15:0] run_len,
    input wire logic [5:0] sel,
    // answers to the block
    output logic motion_busy,
    output logic motion_done,
    output logic [15:0] op_decel_rate
);
    logic [15:0] left_reg;
    logic stopping_reg;

    // per-entry deceleration follows the live selection, as a table lookup would
    assign op_decel_rate = {10'h2c4, sel};

    // a stop cuts the run short and never reports a normal finish
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motion_busy <= 1'b0;
            motion_done <= 1'b0;
            left_reg <= 16'h0;
            stopping_reg <= 1'b0;
        end else begin
            motion_done <= 1'b0;
            if (motion_start) begin
                motion_busy <= 1'b1;
                stopping_reg <= 1'b0;
                left_reg <= run_len;
            end else if (motion_stop && motion_busy) begin
                stopping_reg <= 1'b1;
                left_reg <= stop_immediate ? 16'h1 : 16'h6; // ramp down takes longer
            end else if (motion_busy) begin
                if (left_reg <= 16'h1) begin
                    motion_busy <= 1'b0;
                    motion_done <= !stopping_reg;
                end
                left_reg <= left_reg - 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/sdic_top_asserts.sv
// port-level checker for the stepper drive input control block
`timescale 1ns/10ps
`default_nettype none

module sdic_chk #(
    parameter RDY_FAST_CYC = 20,
    parameter RDY_SLOW_CYC = 50,
    parameter FILT_CYC = 4
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus response
    input wire logic hreadyout,
    input wire logic hresp,
    // control inputs and motion side
    input wire logic windings_off_in,
    input wire logic start_in,
    input wire logic motion_busy,
    input wire logic motion_start,
    input wire logic motion_stop,
    input wire logic stop_immediate,
    input wire logic [5:0] op_number,
    input wire logic op_sequential,
    input wire logic excite_en,
    input wire logic ready_out,
    input wire logic move_out
);
    reg [31:0] excite_cnt_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // cycles with excitation on, saturating so it never wraps
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            excite_cnt_reg <= 32'h0;
        end else if (!excite_en) begin
            excite_cnt_reg <= 32'h0;
        end else if (excite_cnt_reg != 32'hffff_ffff) begin
            excite_cnt_reg <= excite_cnt_reg + 32'h1;
        end
    end

    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus response not ready okay");
    start_pulse_a: assert property (motion_start |=> !motion_start)
        else $error("start request longer than one cycle");
    start_gate_a: assert property (motion_start |-> !$past(move_out))
        else $error("start while moving flag set");
    start_moves_a: assert property (motion_start |-> move_out && excite_en)
        else $error("start without moving flag or excitation");
    start_level_a: assert property (motion_start |-> start_in)
        else $error("start request without start input");
    seq_code_a: assert property (op_sequential == (op_number == 6'h00))
        else $error("sequential flag disagrees with number");
    ready_state_a: assert property (ready_out |-> excite_en && !move_out)
        else $error("ready while unexcited or moving");
    ready_delay_a: assert property (ready_out |-> excite_cnt_reg >= RDY_FAST_CYC - 1)
        else $error("ready too soon after excitation");
    excite_rest_a: assert property ($fell(excite_en) |-> !motion_busy || windings_off_in)
        else $error("excitation dropped while motor moving");
    awo_cut_a: assert property (windings_off_in [*8] ##1 windings_off_in [*4] |=> !excite_en)
        else $error("current not cut by windings off");

    // main scenarios reached
    start_seen_c: cover property (motion_start);
    stop_imm_c: cover property (motion_stop && stop_immediate);
    stop_dec_c: cover property (motion_stop && !stop_immediate);
    ready_back_c: cover property ($rose(ready_out));
endmodule

bind sdic_top sdic_chk #(
    .RDY_FAST_CYC(RDY_FAST_CYC),
    .RDY_SLOW_CYC(RDY_SLOW_CYC),
    .FILT_CYC(FILT_CYC)
) u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .windings_off_in(windings_off_in),
    .start_in(start_in),
    .motion_busy(motion_busy),
    .motion_start(motion_start),
    .motion_stop(motion_stop),
    .stop_immediate(stop_immediate),
    .op_number(op_number),
    .op_sequential(op_sequential),
    .excite_en(excite_en),
    .ready_out(ready_out),
    .move_out(move_out)
);
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the stepper drive input control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, windings_off_in, start_in, stop_in;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic motion_busy, motion_done, motion_start, motion_stop, stop_immediate;
    logic op_sequential, excite_en, ready_out, move_out;
    logic [15:0] op_decel_rate, decel_rate, run_len, lfsr, cd;
    logic [5:0] sel, op_number, s;
    int miscompares, n_checks, n_starts, exp_starts, cycles, i, a, t;

    // short counts keep the run brief
    sdic_top #(.RDY_FAST_CYC(20), .RDY_SLOW_CYC(50), .FILT_CYC(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .windings_off_in(windings_off_in), .start_in(start_in), .stop_in(stop_in),
        .op_select_bit0(sel[0]), .op_select_bit1(sel[1]), .op_select_bit2(sel[2]),
        .op_select_bit3(sel[3]), .op_select_bit4(sel[4]), .op_select_bit5(sel[5]),
        .motion_busy(motion_busy), .motion_done(motion_done), .op_decel_rate(op_decel_rate),
        .motion_start(motion_start), .motion_stop(motion_stop),
        .stop_immediate(stop_immediate), .op_number(op_number),
        .op_sequential(op_sequential), .decel_rate(decel_rate), .excite_en(excite_en),
        .ready_out(ready_out), .move_out(move_out));

    sdic_motion_model u_model (
        .hclk(hclk), .hresetn(hresetn), .motion_start(motion_start),
        .motion_stop(motion_stop), .stop_immediate(stop_immediate), .run_len(run_len),
        .sel(sel), .motion_busy(motion_busy), .motion_done(motion_done),
        .op_decel_rate(op_decel_rate));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // expected per-entry deceleration for a selection
    function automatic logic [15:0] exp_rate(input logic [5:0] v);
        return {10'h2c4, v};
    endfunction

    // one single-word transfer; waits on hready, data taken at the data phase edge
    task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= adr;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk iff hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk iff hreadyout);
        r = hrdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // clock, start counter and hang guard
    // ---------------------------------------------------------------
    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    always @(posedge hclk) begin
        if (motion_start) n_starts <= n_starts + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {hsel, hwrite, windings_off_in, start_in, stop_in, hresetn} = 6'h0;
        {haddr, htrans, hsize, hwdata, sel} = 0;
        run_len = 16'd60;
        lfsr = 16'd23736;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped place reads zero
        ahb(1'b0, 8'h00, 32'h0, q); `CHK(q, 32'h6)
        ahb(1'b0, 8'h04, 32'h0, q); `CHK(q, 32'h0)
        ahb(1'b0, 8'h0c, 32'h0, q); `CHK(q, 32'h0)
        // stop line carrying no current keeps the motor stopped
        cyc(40); `CHK(ready_out, 1'b0)
        `CHK(excite_en, 1'b1)
        stop_in <= 1'b1;
        // positioning over both code ends and random codes
        for (i = 0; i < 10; i++) begin
            s = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : lfsr[5:0];
            lfsr = lfsr_next(lfsr);
            @(posedge hclk iff ready_out);
            sel <= s;
            cyc(2);
            start_in <= 1'b1;
            @(posedge hclk iff motion_start);
            exp_starts++;
            `CHK(op_number, s)
            `CHK(op_sequential, s == 6'h00)
            `CHK(decel_rate, exp_rate(s))
            if (i == 2) begin
                // a fresh edge mid-run must be refused
                start_in <= 1'b0;
                cyc(8);
                start_in <= 1'b1;
            end
            @(posedge hclk iff motion_done);
            cyc(10);
            `CHK(move_out, 1'b1)
            `CHK(n_starts, exp_starts)
            start_in <= 1'b0;
        end
        // every stop action, alternating rate type
        run_len <= 16'd400;
        for (a = 0; a < 4; a++) begin
            cd = lfsr;
            lfsr = lfsr_next(lfsr);
            ahb(1'b1, 8'h04, {16'h0, cd}, q);
            ahb(1'b1, 8'h00, {26'h0, 1'b0, a[0], a[1:0], 2'b10}, q);
            @(posedge hclk iff ready_out);
            start_in <= 1'b1;
            @(posedge hclk iff motion_start);
            cyc(3);
            start_in <= 1'b0;
            stop_in <= 1'b0;
            @(posedge hclk iff motion_stop);
            `CHK(stop_immediate, !a[0])
            `CHK(decel_rate, a[0] ? cd : exp_rate(sel))
            @(posedge hclk iff !motion_busy);
            cyc(4);
            `CHK(excite_en, !a[1])
            cyc(6);
            stop_in <= 1'b1;
        end
        // windings off with misstep detection on
        @(posedge hclk iff ready_out);
        ahb(1'b1, 8'h00, 32'h26, q);
        windings_off_in <= 1'b1;
        cyc(12);
        `CHK(excite_en, 1'b0)
        ahb(1'b0, 8'h08, 32'h0, q); `CHK(q[3], 1'b0)
        windings_off_in <= 1'b0;
        @(posedge hclk iff excite_en);
        t = 0;
        while (!ready_out) begin
            @(posedge hclk);
            t++;
        end
        `CHK(t >= 49 && t <= 54, 1'b1)
        // reversed contacts: no current now cuts windings, current now means stop
        ahb(1'b1, 8'h00, 32'h05, q);
        cyc(3);
        `CHK(excite_en, 1'b0)
        ahb(1'b0, 8'h08, 32'h0, q);
        `CHK(q[5:4], 2'h3)
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ===== verilog/sdic_defs.vh
// constants for the stepper drive input control block
`ifndef SDIC_DEFS_VH
`define SDIC_DEFS_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define SDIC_CLK_KHZ 100000
`define SDIC_RDY_FAST_MS 6
`define SDIC_RDY_SLOW_MS 500
`define SDIC_RDY_FAST_CYC (`SDIC_RDY_FAST_MS * `SDIC_CLK_KHZ)
`define SDIC_RDY_SLOW_CYC (`SDIC_RDY_SLOW_MS * `SDIC_CLK_KHZ)
`define SDIC_FILT_US 1000
`define SDIC_FILT_CYC ((`SDIC_FILT_US * `SDIC_CLK_KHZ) / 1000)

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SDIC_OFS_CTRL 8'h00
`define SDIC_OFS_DECEL 8'h04
`define SDIC_OFS_STATUS 8'h08

// ---------------------------------------------------------------
// control register fields and reset value
// ---------------------------------------------------------------
`define SDIC_CTRL_AWO_NC 0
`define SDIC_CTRL_STOP_NC 1
`define SDIC_CTRL_ACT_LO 2
`define SDIC_CTRL_ACT_HI 3
`define SDIC_CTRL_RATE_COMMON 4
`define SDIC_CTRL_MISSTEP_EN 5
`define SDIC_CTRL_RESET 6'h06
`define SDIC_DECEL_RESET 16'h0000

// ---------------------------------------------------------------
// stop actions
// ---------------------------------------------------------------
`define SDIC_ACT_IMM 2'h0
`define SDIC_ACT_DEC 2'h1
`define SDIC_ACT_IMM_OFF 2'h2
`define SDIC_ACT_DEC_OFF 2'h3

`endif

// ===== verilog/sdic_in_filter.v
// synchroniser and debounce filter for the photocoupler inputs
`timescale 1ns/10ps
`default_nettype none

module sdic_in_filter #(
    parameter WIDTH = 9,
    parameter FILT_CYC = 100000
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // raw and filtered levels, 1 = carrying current
    input wire [WIDTH-1:0] raw,
    output wire [WIDTH-1:0] filt
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg sync1_reg;
            reg sync2_reg;
            reg out_reg;
            reg [31:0] cnt_reg;
            // two-flop synchroniser, first flop read only by second
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                end else begin
                    sync1_reg <= raw[i];
                    sync2_reg <= sync1_reg;
                end
            end
            // level must hold a full filter time before it is accepted
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    out_reg <= 1'b0;
                    cnt_reg <= 32'h0000_0000;
                end else if (sync2_reg == out_reg) begin
                    cnt_reg <= 32'h0000_0000;
                end else if (cnt_reg >= FILT_CYC - 1) begin
                    out_reg <= sync2_reg;
                    cnt_reg <= 32'h0000_0000;
                end else begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                end
            end
            assign filt[i] = out_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== verilog/sdic_top.v
// stepper drive control-input logic with ahb-lite register slave
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "sdic_defs.vh"

module sdic_top #(
    parameter RDY_FAST_CYC = `SDIC_RDY_FAST_CYC,
    parameter RDY_SLOW_CYC = `SDIC_RDY_SLOW_CYC,
    parameter FILT_CYC = `SDIC_FILT_CYC
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // photocoupler inputs, 1 = carrying current
    input wire windings_off_in,
    input wire start_in,
    input wire stop_in,
    input wire op_select_bit0,
    input wire op_select_bit1,
    input wire op_select_bit2,
    input wire op_select_bit3,
    input wire op_select_bit4,
    input wire op_select_bit5,
    // motion generator side
    input wire motion_busy,
    input wire motion_done,
    input wire [15:0] op_decel_rate,
    output reg motion_start,
    output reg motion_stop,
    output reg stop_immediate,
    output reg [5:0] op_number,
    output reg op_sequential,
    output reg [15:0] decel_rate,
    output reg excite_en,
    // status outputs to host
    output wire ready_out,
    output wire move_out
);

    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam ST_OFF = 5'h01;
    localparam ST_SETTLE = 5'h02;
    localparam ST_READY = 5'h04;
    localparam ST_RUN = 5'h08;
    localparam ST_HALT = 5'h10;

    // ---------------------------------------------------------------
    // contact polarity decode
    // ---------------------------------------------------------------
    // normally open: active while current flows; normally closed: reverse
    function active_of;
        input lvl;
        input nc;
        begin
            active_of = nc ? ~lvl : lvl;
        end
    endfunction

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [5:0] ctrl_reg;
    reg [15:0] common_decel_reg;
    reg [31:0] settle_cnt_reg;
    reg hold_off_reg;
    reg move_reg;
    reg start_prev_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    wire [8:0] raw_in;
    wire [8:0] filt_in;
    wire awo_act;
    wire stop_act;
    wire start_lvl;
    wire start_rise;
    wire [5:0] sel_num;
    wire [1:0] stop_action;
    wire act_off;
    wire act_imm;
    wire settle_done;
    wire [15:0] rate_pick;
    wire ahb_go;
    wire start_ok;

    // ---------------------------------------------------------------
    // input conditioning
    // ---------------------------------------------------------------
    // raw levels already mean carrying current, whatever the line voltage
    assign raw_in = {windings_off_in, start_in, stop_in,
                     op_select_bit5, op_select_bit4, op_select_bit3,
                     op_select_bit2, op_select_bit1, op_select_bit0};

    sdic_in_filter #(
        .WIDTH(9),
        .FILT_CYC(FILT_CYC)
    ) u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(raw_in),
        .filt(filt_in)
    );

    // decoded input meanings
    assign awo_act = active_of(filt_in[8], ctrl_reg[`SDIC_CTRL_AWO_NC]);
    // filter resets to no current, so nc stop reads active at power-up
    assign stop_act = active_of(filt_in[6], ctrl_reg[`SDIC_CTRL_STOP_NC]);
    assign start_lvl = filt_in[7];
    assign sel_num = filt_in[5:0];
    assign stop_action = ctrl_reg[`SDIC_CTRL_ACT_HI:`SDIC_CTRL_ACT_LO];
    assign act_off = (stop_action == `SDIC_ACT_IMM_OFF) ||
                     (stop_action == `SDIC_ACT_DEC_OFF);
    assign act_imm = (stop_action == `SDIC_ACT_IMM) ||
                     (stop_action == `SDIC_ACT_IMM_OFF);

    // start edge detect on the filtered level only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_prev_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_lvl;
        end
    end
    assign start_rise = start_lvl & ~start_prev_reg;

    // ---------------------------------------------------------------
    // deceleration choice
    // ---------------------------------------------------------------
    assign rate_pick = ctrl_reg[`SDIC_CTRL_RATE_COMMON] ?
                       common_decel_reg : op_decel_rate;

    // ---------------------------------------------------------------
    // excitation settle timer
    // ---------------------------------------------------------------
    // slow limit used as the wait with misstep detection on, fast limit otherwise
    assign settle_done = ctrl_reg[`SDIC_CTRL_MISSTEP_EN] ?
                         (settle_cnt_reg >= RDY_SLOW_CYC - 1) :
                         (settle_cnt_reg >= RDY_FAST_CYC - 1);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_cnt_reg <= 32'h0000_0000;
        end else if (state_reg != ST_SETTLE) begin
            settle_cnt_reg <= 32'h0000_0000;
        end else if (!settle_done) begin
            settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
        end
    end

    // ---------------------------------------------------------------
    // operation state machine
    // ---------------------------------------------------------------
    // start refused while moving, stopping or with the windings cut off
    assign start_ok = start_rise & ~stop_act & ~move_reg & ~awo_act;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (!awo_act && !hold_off_reg) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (settle_done) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (start_ok) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_act) begin
                    state_next = ST_HALT;
                end else if (motion_done) begin
                    state_next = ST_READY;
                end
            end
            ST_HALT: begin
                // excitation is kept until the motor is at rest
                if (!motion_busy) begin
                    state_next = act_off ? ST_OFF : ST_READY;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        // windings-off overrides every state
        if (awo_act) begin
            state_next = ST_OFF;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // de-energised stop holds off until stop is released again
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_off_reg <= 1'b0;
        end else if (state_reg == ST_HALT && state_next == ST_OFF && act_off) begin
            hold_off_reg <= 1'b1;
        end else if (!stop_act) begin
            hold_off_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // motion generator commands
    // ---------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motion_start <= 1'b0;
            motion_stop <= 1'b0;
            stop_immediate <= 1'b0;
            op_number <= 6'h00;
            op_sequential <= 1'b1;
            decel_rate <= 16'h0000;
            excite_en <= 1'b0;
        end else begin
            motion_start <= (state_reg == ST_READY) && start_ok;
            motion_stop <= 1'b0;
            excite_en <= (state_next != ST_OFF);
            if (state_reg == ST_READY && start_ok) begin
                // selection is taken once, at the start edge
                op_number <= sel_num;
                op_sequential <= (sel_num == 6'h00);
                decel_rate <= rate_pick;
            end
            if ((state_reg == ST_RUN && stop_act) ||
                (state_reg == ST_RUN && awo_act)) begin
                motion_stop <= 1'b1;
                stop_immediate <= act_imm | awo_act;
                decel_rate <= rate_pick;
            end
        end
    end

    // ---------------------------------------------------------------
    // moving flag
    // ---------------------------------------------------------------
    // stays set after the move ends while start is still held
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            move_reg <= 1'b0;
        end else if (state_reg == ST_READY && start_ok) begin
            move_reg <= 1'b1;
        end else if (state_reg != ST_RUN && state_reg != ST_HALT &&
                     !motion_busy && !start_lvl) begin
            move_reg <= 1'b0;
        end
    end

    assign move_out = move_reg;
    assign ready_out = (state_reg == ST_READY) & ~move_reg & ~stop_act;

    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ahb_go = hsel & htrans[1] & hready;

    // address phase capture for writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= ahb_go & hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // data phase write; unmapped offsets ignored
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `SDIC_CTRL_RESET;
            common_decel_reg <= `SDIC_DECEL_RESET;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == `SDIC_OFS_CTRL) begin
                ctrl_reg <= hwdata[5:0];
            end
            if (wr_addr_reg == `SDIC_OFS_DECEL) begin
                common_decel_reg <= hwdata[15:0];
            end
        end
    end

    // read data sampled in the address phase, so it is a flop output
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_go && !hwrite) begin
            case (haddr)
                `SDIC_OFS_CTRL: begin
                    hrdata <= {26'h0000000, ctrl_reg};
                end
                `SDIC_OFS_DECEL: begin
                    hrdata <= {16'h0000, common_decel_reg};
                end
                `SDIC_OFS_STATUS: begin
                    hrdata <= {10'h000, sel_num, 3'h0, state_reg,
                               2'h0, awo_act, stop_act,
                               excite_en, move_reg, ready_out, hold_off_reg};
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

`default_nettype wire
